// *** pkg/core_irq_pkg.sv ***
// package for the core interrupt control block: register map, field layout,
// reset values and the state carrier.
// assumes a 12-bit apb byte address and 32-bit data.
package core_irq_pkg;

  // printed offsets are word indices; the byte address is four times the index
  localparam logic [9:0] IC_IDX_BANK0 = 10'h00b;
  localparam logic [9:0] IC_IDX_BANK1 = 10'h08b;
  localparam logic [9:0] IC_IDX_BANK2 = 10'h10b;
  localparam logic [9:0] IC_IDX_BANK3 = 10'h18b;

  // event status and mask
  localparam logic [11:0] EV_STATUS_ADDR = 12'h800;
  localparam logic [11:0] EV_MASK_ADDR = 12'h804;

  // event positions in status and mask
  localparam int EV_TIMER0 = 0;
  localparam int EV_EXT_PIN = 1;
  localparam int EV_PORT_CHG = 2;
  localparam int EV_COUNT = 3;

  // bit 7 down to bit 0
  typedef struct packed {
    logic global_irq_enable;
    logic peripheral_irq_enable;
    logic timer0_wrap_irq_enable;
    logic ext_pin_irq_enable;
    logic port_change_irq_enable;
    logic timer0_wrap_flag;
    logic ext_pin_flag;
    logic port_change_flag;
  } interrupt_control_s;

  localparam logic [7:0] IC_RESET = 8'h00;
  localparam logic [2:0] EV_STATUS_RESET = 3'h0;
  localparam logic [2:0] EV_MASK_RESET = 3'h0;
  localparam logic [3:0] PB_REF_RESET = 4'h0;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  typedef struct packed {
    interrupt_control_s ic;
    logic [2:0] ev_status;
    logic [2:0] ev_mask;
    logic [3:0] pb_ref;
    logic pb_valid;
    logic ext_prev;
    logic [31:0] rdata;
  } ctl_state_s;

endpackage

// *** hdl/core_interrupt_control.sv ***
// core interrupt control register with enables and flags for timer0 wrap,
// upper port b change and the external pin, plus an event status/mask pair.
// assumes an apb master on mclk; all event inputs are synchronous to mclk.

module core_interrupt_control #(
  parameter int PB_WIDTH = 4
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer0_wrap,
  input wire logic ext_irq_pin,
  input wire logic [PB_WIDTH-1:0] port_b_data,
  input wire logic port_b_read,
  input wire logic periph_irq_req,
  output logic core_irq_req,
  output logic irq
);

  logic [1:0] rst_sync_ff;
  logic rst_n;
  core_irq_pkg::ctl_state_s state_ff;
  core_irq_pkg::ctl_state_s nxt_state;
  logic ic_hit;
  logic st_hit;
  logic mk_hit;
  logic mapped;
  logic setup_ph;
  logic access_ph;
  logic wr_acc;
  logic ev_timer0;
  logic ev_ext;
  logic ev_port;
  logic [2:0] ev_vec;
  logic [7:0] ic_bits;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // address decode
  always_comb begin
    ic_hit = 1'b0;
    st_hit = 1'b0;
    mk_hit = 1'b0;
    if (paddr == {core_irq_pkg::IC_IDX_BANK0, 2'b00}) begin
      ic_hit = 1'b1;
    end else if (paddr == {core_irq_pkg::IC_IDX_BANK1, 2'b00}) begin
      ic_hit = 1'b1;
    end else if (paddr == {core_irq_pkg::IC_IDX_BANK2, 2'b00}) begin
      ic_hit = 1'b1;
    end else if (paddr == {core_irq_pkg::IC_IDX_BANK3, 2'b00}) begin
      ic_hit = 1'b1;
    end else if (paddr == core_irq_pkg::EV_STATUS_ADDR) begin
      st_hit = 1'b1;
    end else if (paddr == core_irq_pkg::EV_MASK_ADDR) begin
      mk_hit = 1'b1;
    end
  end

  assign mapped = ic_hit | st_hit | mk_hit;
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign wr_acc = access_ph & pwrite & mapped;

  // read data is captured in setup, so every access completes without wait
  assign pready = access_ph;
  assign pslverr = access_ph & ~mapped;
  assign prdata = state_ff.rdata;

  // event detection
  assign ev_timer0 = timer0_wrap;
  // rising edge of the external pin
  assign ev_ext = ext_irq_pin & ~state_ff.ext_prev;
  // mismatch keeps setting the flag until port b is read
  assign ev_port = state_ff.pb_valid &
                   (port_b_data[PB_WIDTH-1:PB_WIDTH-4] != state_ff.pb_ref);
  assign ev_vec = {ev_port, ev_ext, ev_timer0};
  assign ic_bits = state_ff.ic;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.ext_prev = ext_irq_pin;
    // reference latched on a port read, and once after reset
    if (port_b_read || !state_ff.pb_valid) begin
      nxt_state.pb_ref = port_b_data[PB_WIDTH-1:PB_WIDTH-4];
      nxt_state.pb_valid = 1'b1;
    end
    if (setup_ph && !pwrite) begin
      nxt_state.rdata = core_irq_pkg::RDATA_RESET;
      if (ic_hit) begin
        nxt_state.rdata = {24'h00_0000, ic_bits};
      end else if (st_hit) begin
        nxt_state.rdata = {29'h0000_0000, state_ff.ev_status};
      end else if (mk_hit) begin
        nxt_state.rdata = {29'h0000_0000, state_ff.ev_mask};
      end
    end
    // plain read/write of all eight bits
    // flags clear only through this write
    if (wr_acc && ic_hit) begin
      nxt_state.ic = core_irq_pkg::interrupt_control_s'(pwdata[7:0]);
    end
    if (wr_acc && mk_hit) begin
      nxt_state.ev_mask = pwdata[2:0];
    end
    // write one to clear; a same-cycle event wins below
    if (wr_acc && st_hit) begin
      nxt_state.ev_status = state_ff.ev_status & ~pwdata[2:0];
    end
    nxt_state.ev_status = nxt_state.ev_status | ev_vec;
    if (ev_timer0) begin
      nxt_state.ic.timer0_wrap_flag = 1'b1;
    end
    if (ev_ext) begin
      nxt_state.ic.ext_pin_flag = 1'b1;
    end
    if (ev_port) begin
      nxt_state.ic.port_change_flag = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff.ic <= core_irq_pkg::interrupt_control_s'(core_irq_pkg::IC_RESET);
      state_ff.ev_status <= core_irq_pkg::EV_STATUS_RESET;
      state_ff.ev_mask <= core_irq_pkg::EV_MASK_RESET;
      state_ff.pb_ref <= core_irq_pkg::PB_REF_RESET;
      state_ff.pb_valid <= 1'b0;
      state_ff.ext_prev <= 1'b0;
      state_ff.rdata <= core_irq_pkg::RDATA_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign core_irq_req = state_ff.ic.global_irq_enable & (
    (state_ff.ic.timer0_wrap_irq_enable & state_ff.ic.timer0_wrap_flag) |
    (state_ff.ic.ext_pin_irq_enable & state_ff.ic.ext_pin_flag) |
    (state_ff.ic.port_change_irq_enable & state_ff.ic.port_change_flag) |
    (state_ff.ic.peripheral_irq_enable & periph_irq_req));

  assign irq = |(state_ff.ev_status & state_ff.ev_mask);

  // a stale flag left set before enabling fires at once; software must clear it first
  // design relies on software order

  sequence s_ic_write;
    setup_ph && pwrite && ic_hit ##1 access_ph && pwrite && ic_hit;
  endsequence

  sequence s_ic_read;
    setup_ph && !pwrite && ic_hit ##1 access_ph;
  endsequence

  sequence s_quiet;
    !ev_timer0 && !ev_ext && !ev_port;
  endsequence

  sequence s_stray_read;
    setup_ph && !pwrite && !mapped ##1 access_ph;
  endsequence

  chk_timer0_flag_set: assert property (
    @(posedge mclk) disable iff (!rst_n)
    timer0_wrap |=> state_ff.ic.timer0_wrap_flag
  ) else $error("timer0 wrap flag not set after event");

  chk_ext_flag_set: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $rose(ext_irq_pin) && $past(rst_n) |=> state_ff.ic.ext_pin_flag
  ) else $error("external pin flag not set after rising edge");

  chk_global_gate: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !state_ff.ic.global_irq_enable |-> !core_irq_req
  ) else $error("core request while global enable is clear");

  chk_timer0_request: assert property (
    @(posedge mclk) disable iff (!rst_n)
    timer0_wrap && state_ff.ic.global_irq_enable &&
    state_ff.ic.timer0_wrap_irq_enable && !(wr_acc && ic_hit)
    |=> core_irq_req
  ) else $error("enabled timer0 event raised no core request");

  chk_write_readback: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (s_ic_write ##0 s_quiet) |=> (state_ff.ic == $past(pwdata[7:0]))
  ) else $error("control register does not hold written value");

  chk_mirror_read: assert property (
    @(posedge mclk) disable iff (!rst_n)
    s_ic_read |-> (prdata == {24'h00_0000, $past(ic_bits)}) && pready && !pslverr
  ) else $error("mirrored read returned wrong data");

  chk_flag_hold: assert property (
    @(posedge mclk) disable iff (!rst_n)
    state_ff.ic.port_change_flag && !(wr_acc && ic_hit) |=>
    state_ff.ic.port_change_flag
  ) else $error("port change flag cleared without a write");

  chk_port_mismatch: assert property (
    @(posedge mclk) disable iff (!rst_n)
    ev_port |=> state_ff.ic.port_change_flag && state_ff.ev_status[2]
  ) else $error("port mismatch did not set flag and status");

  chk_status_irq: assert property (
    @(posedge mclk) disable iff (!rst_n)
    ev_ext && state_ff.ev_mask[1] && !(wr_acc && (mk_hit || st_hit)) |=> irq [*2]
  ) else $error("unmasked event did not hold the interrupt line");

  chk_unmapped_err: assert property (
    @(posedge mclk) disable iff (!rst_n)
    access_ph && !mapped |-> pslverr && pready
  ) else $error("unmapped access not answered with error");

  chk_ext_flag_hold: assert property (
    @(posedge mclk) disable iff (!rst_n)
    state_ff.ic.ext_pin_flag && !(wr_acc && ic_hit) |=> state_ff.ic.ext_pin_flag
  ) else $error("external pin flag cleared without a write");

  chk_timer0_flag_hold: assert property (
    @(posedge mclk) disable iff (!rst_n)
    state_ff.ic.timer0_wrap_flag && !(wr_acc && ic_hit) |=> state_ff.ic.timer0_wrap_flag
  ) else $error("timer0 wrap flag cleared without a write");

  // a steady high pin is no event; the first cycle out of reset is skipped
  chk_ext_level_quiet: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $past(rst_n) && $stable(ext_irq_pin) && !state_ff.ic.ext_pin_flag &&
    !(wr_acc && ic_hit) |=> !state_ff.ic.ext_pin_flag
  ) else $error("external pin flag set without a rising edge");

  chk_port_quiet: assert property (
    @(posedge mclk) disable iff (!rst_n)
    state_ff.pb_valid && (port_b_data[PB_WIDTH-1:PB_WIDTH-4] == state_ff.pb_ref) &&
    !state_ff.ic.port_change_flag && !(wr_acc && ic_hit) |=> !state_ff.ic.port_change_flag
  ) else $error("port change flag set without a mismatch");

  chk_timer0_status: assert property (
    @(posedge mclk) disable iff (!rst_n)
    timer0_wrap |=> state_ff.ev_status[core_irq_pkg::EV_TIMER0]
  ) else $error("timer0 wrap did not set its status bit");

  chk_ext_status: assert property (
    @(posedge mclk) disable iff (!rst_n)
    ev_ext |=> state_ff.ev_status[core_irq_pkg::EV_EXT_PIN]
  ) else $error("external pin edge did not set its status bit");

  chk_status_hold: assert property (
    @(posedge mclk) disable iff (!rst_n)
    state_ff.ev_status[core_irq_pkg::EV_EXT_PIN] && !(wr_acc && st_hit) |=>
    state_ff.ev_status[core_irq_pkg::EV_EXT_PIN]
  ) else $error("status bit cleared without a status write");

  chk_mask_write: assert property (
    @(posedge mclk) disable iff (!rst_n)
    wr_acc && mk_hit |=> state_ff.ev_mask == $past(pwdata[2:0])
  ) else $error("mask register does not hold written value");

  chk_zero_wait: assert property (
    @(posedge mclk) disable iff (!rst_n)
    access_ph |-> pready
  ) else $error("access phase not answered at once");

  chk_idle_quiet: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !access_ph |-> !pready && !pslverr
  ) else $error("ready or error outside an access phase");

  chk_periph_request: assert property (
    @(posedge mclk) disable iff (!rst_n)
    state_ff.ic.global_irq_enable && state_ff.ic.peripheral_irq_enable && periph_irq_req
    |-> core_irq_req
  ) else $error("enabled peripheral request raised no core request");

  chk_stray_read_zero: assert property (
    @(posedge mclk) disable iff (!rst_n)
    s_stray_read |-> prdata == core_irq_pkg::RDATA_RESET
  ) else $error("unmapped read returned nonzero data");

  chk_stray_write_kept: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (access_ph && pwrite && !mapped ##0 s_quiet) |=>
    (state_ff.ic == $past(state_ff.ic)) && (state_ff.ev_mask == $past(state_ff.ev_mask))
  ) else $error("unmapped write changed a register");

endmodule

// *** test/core_interrupt_control_bench.sv ***
// self-checking bench for the core interrupt control block.
// assumes the block answers apb with no wait states and events on mclk.
module core_interrupt_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd_v;
  logic pready, pslverr, er_v, core_irq_req, irq;
  logic timer0_wrap = 0, ext_irq_pin = 0, port_b_read = 0, periph_irq_req = 0;
  logic [3:0] port_b_data = 4'h0;
  int n_errors = 0, n_checks = 0, cyc = 0;
  logic [11:0] ic_a [4];
  localparam logic [11:0] ST = core_irq_pkg::EV_STATUS_ADDR;
  localparam logic [11:0] MK = core_irq_pkg::EV_MASK_ADDR;

  core_interrupt_control #(.PB_WIDTH(4)) DUT (.mclk(mclk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer0_wrap(timer0_wrap),
    .ext_irq_pin(ext_irq_pin), .port_b_data(port_b_data), .port_b_read(port_b_read),
    .periph_irq_req(periph_irq_req), .core_irq_req(core_irq_req), .irq(irq));

  initial begin
    forever #4 mclk = ~mclk;
  end

  task automatic end_of_test;
    if (n_errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // a hung handshake would otherwise stall the run forever
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      $display("[ERR] %s expected %h seen %h", n, x, g);
      n_errors++;
    end
  endtask

  // entered just after a rising edge; returns one idle edge after the edge that took pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd_v = prdata;
    er_v = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string n);
    apb(0, a, 32'h0000_0000);
    chk(n, x, rd_v);
  endtask

  // outputs are judged mid-cycle, once the edge's updates have landed
  task automatic see(input logic req, input logic ir);
    @(negedge mclk);
    chk("core_irq_req", {31'h0, req}, {31'h0, core_irq_req});
    chk("irq", {31'h0, ir}, {31'h0, irq});
    @(posedge mclk);
  endtask

  task automatic t_mirror;
    for (int i = 0; i < 4; i++) rd(ic_a[i], 32'h0000_0000, "ctl_reset");
    apb(1, ic_a[1], 32'hffff_fff8);
    for (int i = 0; i < 4; i++) rd(ic_a[i], 32'h0000_00f8, "ctl_mirror");
    apb(1, ic_a[3], 32'h0000_0000);
    rd(ic_a[0], 32'h0000_0000, "ctl_cleared");
  endtask

  task automatic t_flags;
    timer0_wrap <= 1;
    ext_irq_pin <= 1;
    port_b_data <= 4'h5;
    @(posedge mclk);
    timer0_wrap <= 0;
    port_b_read <= 1;
    @(posedge mclk);
    port_b_read <= 0;
    see(0, 0);
    rd(ic_a[2], 32'h0000_0007, "ctl_flags");
    rd(ST, 32'h0000_0007, "status");
  endtask

  task automatic t_gate;
    apb(1, ic_a[0], 32'h0000_0027);
    see(0, 0);
    apb(1, ic_a[0], 32'h0000_00a7);
    see(1, 0);
    apb(1, ic_a[0], 32'h0000_00a3);
    see(0, 0);
    timer0_wrap <= 1;
    @(posedge mclk);
    timer0_wrap <= 0;
    see(1, 0);
    apb(1, ic_a[0], 32'h0000_0000);
    apb(1, ic_a[0], 32'h0000_00b8);
    see(0, 0);
    periph_irq_req <= 1;
    apb(1, ic_a[0], 32'h0000_0040);
    see(0, 0);
    apb(1, ic_a[0], 32'h0000_00c0);
    see(1, 0);
    periph_irq_req <= 0;
    @(posedge mclk);
    see(0, 0);
  endtask

  task automatic t_irq;
    apb(1, MK, 32'h0000_0002);
    see(0, 1);
    apb(1, ST, 32'h0000_0002);
    see(0, 0);
    rd(ST, 32'h0000_0005, "status_w1c");
    rd(MK, 32'h0000_0002, "mask");
    apb(1, ST, 32'h0000_0005);
    rd(ST, 32'h0000_0000, "status_clear");
    ext_irq_pin <= 0;
    @(posedge mclk);
    ext_irq_pin <= 1;
    @(posedge mclk);
    see(0, 1);
    rd(ST, 32'h0000_0002, "status_ext");
    rd(ic_a[1], 32'h0000_00c2, "ctl_ext_flag");
    apb(1, 12'h100, 32'h0000_00ff);
    chk("pslverr", 32'h1, {31'h0, er_v});
    rd(12'h100, 32'h0000_0000, "unmapped");
    chk("pslverr_rd", 32'h1, {31'h0, er_v});
  endtask

  initial begin
    ic_a[0] = {core_irq_pkg::IC_IDX_BANK0, 2'b00};
    ic_a[1] = {core_irq_pkg::IC_IDX_BANK1, 2'b00};
    ic_a[2] = {core_irq_pkg::IC_IDX_BANK2, 2'b00};
    ic_a[3] = {core_irq_pkg::IC_IDX_BANK3, 2'b00};
    repeat (12) @(posedge mclk);
    arst_n <= 1;
    repeat (3) @(posedge mclk);
    t_mirror();
    t_flags();
    t_gate();
    t_irq();
    end_of_test();
  end
endmodule
